// ==== rtl/pin_function_reset_defaults.v ====
// pin function logic: general pins, low speed clock pin, serial data pins, reset and sleep pins
// assumes a classic wishbone master on mclk_i and core signals on the same clock;
// all pin inputs are asynchronous and pass input_sync first
`include "pin_function_defines.vh"

module pin_function_reset_defaults #(
    parameter OSC_MODULE_VARIANT = 0,
    parameter CLK_OUT_DIV = 2
) (
    // clock and reset
    input wire mclk_i,
    input wire rst_i,
    // wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [8:0] adr_i,
    input wire [31:0] dat_i,
    input wire [3:0] sel_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // reset and power pins
    input wire hard_reset_n_i,
    input wire regulator_powerdown_in_i,
    // serial pins
    input wire serial_select_n_i,
    input wire serial_data_in_i,
    output reg serial_data_out_o,
    output reg serial_data_out_oe_o,
    // low speed clock pin
    input wire low_speed_clock_pin_i,
    output reg low_speed_clock_pin_o,
    output reg low_speed_clock_pin_oe_o,
    // general pins
    input wire [3:0] general_pin_i,
    output reg [3:0] general_pin_o,
    output reg [3:0] general_pin_oe_o,
    // core side
    input wire interrupt_req_i,
    input wire antenna_sel_i,
    input wire trx_sel_i,
    input wire spi_read_data_i,
    input wire direct_mode_bit_clock_i,
    output reg core_reset_o,
    output reg deep_sleep_o,
    output reg rtc_tick_o,
    output reg spi_write_data_o,
    output reg direct_mode_data_o,
    output reg [3:0] general_pin_level_o
);

// synchronised pin levels
wire [8:0] pins_sync;
wire hard_reset_n_sync;
wire powerdown_sync;
wire select_n_sync;
wire serial_in_sync;
wire ls_pin_sync;
wire [3:0] gp_sync;

input_sync #(
    .WIDTH(9),
    .RESET_VAL(9'h040)
) u_pin_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .async_i({hard_reset_n_i, regulator_powerdown_in_i, serial_select_n_i,
              serial_data_in_i, low_speed_clock_pin_i, general_pin_i}),
    .sync_o(pins_sync)
);

assign hard_reset_n_sync = pins_sync[8];
assign powerdown_sync = pins_sync[7];
assign select_n_sync = pins_sync[6];
assign serial_in_sync = pins_sync[5];
assign ls_pin_sync = pins_sync[4];
assign gp_sync = pins_sync[3:0];

// registers lose their contents in deep sleep as well as in hard reset
wire core_rst;
assign core_rst = rst_i | ~hard_reset_n_sync | powerdown_sync;

// control registers
reg [7:0] clock_source_setting_reg;
reg [7:0] pin_zero_control_reg;
reg [7:0] pin_one_control_reg;
reg [7:0] pin_two_control_reg;
reg [7:0] pin_three_control_reg;
reg [7:0] low_speed_clock_pin_control_reg;
reg [7:0] serial_mode_reg;

wire [31:0] pin_ctrl_bus;
assign pin_ctrl_bus = {pin_three_control_reg, pin_two_control_reg,
                       pin_one_control_reg, pin_zero_control_reg};

wire osc_module_enable;
wire crystal_enable;
wire direct_mode;
assign osc_module_enable = clock_source_setting_reg[`OSC_MODULE_ENABLE_BIT];
assign crystal_enable = clock_source_setting_reg[`CRYSTAL_ENABLE_BIT];
assign direct_mode = serial_mode_reg[`DIRECT_MODE_BIT];

// wishbone decode
wire [6:0] reg_idx;
wire bus_req;
wire bus_write;
assign reg_idx = adr_i[8:2];
assign bus_req = cyc_i & stb_i;
// a write lands on the edge at which the master sees ack
assign bus_write = bus_req & we_i & ack_o & sel_i[0];

wire [7:0] status_byte;
assign status_byte = {gp_sync, 1'b0, ls_pin_sync, deep_sleep_o,
                      osc_module_enable & crystal_enable};

function [7:0] read_mux;
    input [6:0] idx;
    begin
        case (idx)
            `REG_CLOCK_SOURCE_IDX: read_mux = clock_source_setting_reg;
            `REG_PIN_ZERO_IDX: read_mux = pin_zero_control_reg;
            `REG_PIN_ONE_IDX: read_mux = pin_one_control_reg;
            `REG_PIN_TWO_IDX: read_mux = pin_two_control_reg;
            `REG_PIN_THREE_IDX: read_mux = pin_three_control_reg;
            `REG_LOW_SPEED_PIN_IDX: read_mux = low_speed_clock_pin_control_reg;
            `REG_PIN_STATUS_IDX: read_mux = status_byte;
            `REG_SERIAL_MODE_IDX: read_mux = serial_mode_reg;
            default: read_mux = 8'h00;
        endcase
    end
endfunction

// bus slave answers one cycle after the request; ack drops after one cycle
always @(posedge mclk_i)
begin
    if (rst_i)
    begin
        ack_o <= 1'b0;
        dat_o <= 32'h0000_0000;
    end
    else
    begin
        ack_o <= bus_req & ~ack_o;
        if (bus_req & ~ack_o & ~we_i)
        begin
            dat_o <= {24'h00_0000, read_mux(reg_idx)};
        end
    end
end

always @(posedge mclk_i)
begin
    if (core_rst)
    begin
        clock_source_setting_reg <= `RST_CLOCK_SOURCE;
        pin_zero_control_reg <= `RST_PIN_ZERO;
        pin_one_control_reg <= `RST_PIN_ONE;
        pin_two_control_reg <= `RST_PIN_TWO;
        pin_three_control_reg <= `RST_PIN_THREE;
        low_speed_clock_pin_control_reg <= `RST_LOW_SPEED_PIN;
        serial_mode_reg <= `RST_SERIAL_MODE;
    end
    else if (bus_write)
    begin
        case (reg_idx)
            `REG_CLOCK_SOURCE_IDX: clock_source_setting_reg <= dat_i[7:0];
            `REG_PIN_ZERO_IDX: pin_zero_control_reg <= dat_i[7:0];
            `REG_PIN_ONE_IDX: pin_one_control_reg <= dat_i[7:0];
            `REG_PIN_TWO_IDX: pin_two_control_reg <= dat_i[7:0];
            `REG_PIN_THREE_IDX: pin_three_control_reg <= dat_i[7:0];
            `REG_LOW_SPEED_PIN_IDX: low_speed_clock_pin_control_reg <= dat_i[7:0];
            `REG_SERIAL_MODE_IDX: serial_mode_reg <= dat_i[7:0];
            default: serial_mode_reg <= serial_mode_reg;
        endcase
    end
end

// clock output source: divided master clock
reg [7:0] div_count_reg;
reg clk_out_reg;
wire clk_out_allowed;
assign clk_out_allowed = (OSC_MODULE_VARIANT == 0) | osc_module_enable;

always @(posedge mclk_i)
begin
    if (core_rst | ~clk_out_allowed)
    begin
        div_count_reg <= 8'h00;
        clk_out_reg <= 1'b0;
    end
    else if (div_count_reg == CLK_OUT_DIV[7:0] - 8'h01)
    begin
        div_count_reg <= 8'h00;
        clk_out_reg <= ~clk_out_reg;
    end
    else
    begin
        div_count_reg <= div_count_reg + 8'h01;
    end
end

// returns {drive, level} for one general pin
function [1:0] pin_drive;
    input [2:0] func;
    input irq;
    input clk;
    input ant;
    input trx;
    input value;
    begin
        case (func)
            `FUNC_DISABLED: pin_drive = 2'b00;
            `FUNC_INTERRUPT: pin_drive = {1'b1, irq};
            `FUNC_CLOCK_OUT: pin_drive = {1'b1, clk};
            `FUNC_ANTENNA_SEL: pin_drive = {1'b1, ant};
            `FUNC_TRX_SEL: pin_drive = {1'b1, trx};
            `FUNC_DRIVE_VALUE: pin_drive = {1'b1, value};
            `FUNC_INPUT: pin_drive = 2'b00;
            default: pin_drive = 2'b00;
        endcase
    end
endfunction

// general pins, all outputs released while the block is held in reset
genvar gi;
generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_pin
        wire [7:0] ctrl;
        wire [1:0] drv;
        wire od;
        assign ctrl = pin_ctrl_bus[gi*8 +: 8];
        assign od = ctrl[`PIN_OPEN_DRAIN_BIT];
        assign drv = pin_drive(ctrl[`PIN_FUNC_MSB:`PIN_FUNC_LSB], interrupt_req_i,
                               clk_out_reg & clk_out_allowed, antenna_sel_i, trx_sel_i,
                               ctrl[`PIN_OUT_VALUE_BIT]);

        always @(posedge mclk_i)
        begin
            if (core_rst)
            begin
                general_pin_o[gi] <= 1'b0;
                general_pin_oe_o[gi] <= 1'b0;
                general_pin_level_o[gi] <= 1'b0;
            end
            else
            begin
                // open drain only pulls low
                general_pin_o[gi] <= od ? 1'b0 : drv[0];
                general_pin_oe_o[gi] <= od ? (drv[1] & ~drv[0]) : drv[1];
                general_pin_level_o[gi] <= gp_sync[gi];
            end
        end
    end
endgenerate

// low speed clock pin
wire [2:0] ls_func;
reg ls_prev_reg;
assign ls_func = low_speed_clock_pin_control_reg[`PIN_FUNC_MSB:`PIN_FUNC_LSB];

always @(posedge mclk_i)
begin
    if (core_rst)
    begin
        low_speed_clock_pin_o <= 1'b0;
        low_speed_clock_pin_oe_o <= 1'b0;
        ls_prev_reg <= ls_pin_sync; // no false edge when reset ends with the pin high
        rtc_tick_o <= 1'b0;
    end
    else
    begin
        ls_prev_reg <= ls_pin_sync;
        // one pulse per rising edge of the external real time clock
        rtc_tick_o <= (ls_func == `LS_FUNC_RTC_INPUT) & ls_pin_sync & ~ls_prev_reg;
        low_speed_clock_pin_oe_o <= (ls_func == `LS_FUNC_DRIVE_VALUE);
        low_speed_clock_pin_o <= (ls_func == `LS_FUNC_DRIVE_VALUE) &
                                 low_speed_clock_pin_control_reg[`PIN_OUT_VALUE_BIT];
    end
end

// serial data pins
always @(posedge mclk_i)
begin
    if (core_rst)
    begin
        serial_data_out_o <= 1'b0;
        serial_data_out_oe_o <= 1'b0;
        spi_write_data_o <= 1'b0;
        direct_mode_data_o <= 1'b0;
    end
    else if (direct_mode)
    begin
        serial_data_out_o <= direct_mode_bit_clock_i;
        serial_data_out_oe_o <= 1'b1;
        spi_write_data_o <= 1'b0;
        direct_mode_data_o <= serial_in_sync;
    end
    else
    begin
        serial_data_out_o <= spi_read_data_i;
        serial_data_out_oe_o <= ~select_n_sync;
        spi_write_data_o <= serial_in_sync & ~select_n_sync;
        direct_mode_data_o <= 1'b0;
    end
end

// reset and sleep status toward the core
always @(posedge mclk_i)
begin
    if (rst_i)
    begin
        core_reset_o <= 1'b1;
        deep_sleep_o <= 1'b0;
    end
    else
    begin
        core_reset_o <= ~hard_reset_n_sync;
        deep_sleep_o <= powerdown_sync;
    end
end

endmodule // pin_function_reset_defaults

// ==== rtl/pin_function_defines.vh ====
// register indices, field positions, reset values and function codes of the pin function block
// assumes register byte address = 4 * index on a 32-bit classic wishbone bus
`ifndef PIN_FUNCTION_DEFINES_VH
`define PIN_FUNCTION_DEFINES_VH

// register indices
`define REG_CLOCK_SOURCE_IDX 7'h03
`define REG_PIN_ZERO_IDX 7'h4e
`define REG_PIN_ONE_IDX 7'h4f
`define REG_PIN_TWO_IDX 7'h50
`define REG_PIN_THREE_IDX 7'h51
`define REG_LOW_SPEED_PIN_IDX 7'h52
`define REG_PIN_STATUS_IDX 7'h60
`define REG_SERIAL_MODE_IDX 7'h61

// clock source setting fields
`define OSC_MODULE_ENABLE_BIT 6
`define CRYSTAL_ENABLE_BIT 4

// pin control fields
`define PIN_FUNC_MSB 2
`define PIN_FUNC_LSB 0
`define PIN_OUT_VALUE_BIT 3
`define PIN_OPEN_DRAIN_BIT 4

// serial mode fields
`define DIRECT_MODE_BIT 0

// status fields
`define STAT_REF_CONFLICT_BIT 0
`define STAT_DEEP_SLEEP_BIT 1
`define STAT_LS_PIN_LEVEL_BIT 2
`define STAT_PIN_LEVEL_LSB 4

// general pin function codes
`define FUNC_DISABLED 3'h0
`define FUNC_INTERRUPT 3'h1
`define FUNC_CLOCK_OUT 3'h2
`define FUNC_ANTENNA_SEL 3'h3
`define FUNC_TRX_SEL 3'h4
`define FUNC_DRIVE_VALUE 3'h5
`define FUNC_INPUT 3'h6

// low speed clock pin function codes
`define LS_FUNC_RTC_INPUT 3'h0
`define LS_FUNC_DRIVE_VALUE 3'h1

// reset values
`define RST_CLOCK_SOURCE 8'h00
`define RST_PIN_ZERO 8'h01
`define RST_PIN_ONE 8'h02
`define RST_PIN_TWO 8'h03
`define RST_PIN_THREE 8'h04
`define RST_LOW_SPEED_PIN 8'h00
`define RST_SERIAL_MODE 8'h00

// nominal external real time clock rate on the low speed pin
`define LS_CLOCK_NOMINAL_HZ 32000

`endif

// ==== rtl/input_sync.v ====
// two flip-flop synchroniser for a bundle of asynchronous levels
// assumes each bit is an independent level; no bus coherency is given
module input_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    // clock and reset
    input wire mclk_i,
    input wire rst_i,
    // levels
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

reg [WIDTH-1:0] stage1_reg;
reg [WIDTH-1:0] stage2_reg;

always @(posedge mclk_i)
begin
    if (rst_i)
    begin
        stage1_reg <= RESET_VAL;
        stage2_reg <= RESET_VAL;
    end
    else
    begin
        stage1_reg <= async_i;
        stage2_reg <= stage1_reg;
    end
end

assign sync_o = stage2_reg;

endmodule // input_sync

// ==== verif/pin_function_sva.sv ====
// checker: bus answer, reset, sleep, serial and rtc timing at the top ports
// assumes a bind onto pin_function_reset_defaults, all on mclk_i
module pin_function_sva (
    // clock and reset
    input wire mclk_i,
    input wire rst_i,
    // bus
    input wire cyc_i,
    input wire stb_i,
    input wire ack_o,
    input wire [31:0] dat_o,
    // pins
    input wire hard_reset_n_i,
    input wire regulator_powerdown_in_i,
    input wire serial_select_n_i,
    input wire serial_data_in_i,
    input wire low_speed_clock_pin_i,
    input wire [3:0] general_pin_oe_o,
    // core side
    input wire core_reset_o,
    input wire deep_sleep_o,
    input wire rtc_tick_o,
    input wire spi_write_data_o,
    input wire direct_mode_data_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_held;
        !hard_reset_n_i [*5];
    endsequence
    sequence s_sleep;
        regulator_powerdown_in_i [*5];
    endsequence
    sequence s_run;
        (hard_reset_n_i && !regulator_powerdown_in_i) [*5];
    endsequence
    sequence s_sel_one;
        (!serial_select_n_i && serial_data_in_i) [*5];
    endsequence
    a_ack_answer: assert property (s_req |=> ack_o) else $error("no ack");
    a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack too long");
    a_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h00_0000) else $error("upper");
    a_hard_reset: assert property (s_held |-> core_reset_o && general_pin_oe_o == 4'h0)
        else $error("reset not held");
    a_run_normal: assert property (s_run |-> !core_reset_o && !deep_sleep_o)
        else $error("not running");
    a_sleep_enter: assert property (s_sleep |-> deep_sleep_o && general_pin_oe_o == 4'h0)
        else $error("no deep sleep");
    a_serial_in: assert property (s_sel_one |->
        core_reset_o || deep_sleep_o || spi_write_data_o || direct_mode_data_o)
        else $error("serial in lost");
    a_rtc_tick: assert property (rtc_tick_o |->
        $past(low_speed_clock_pin_i, 3) && !$past(low_speed_clock_pin_i, 4))
        else $error("stray tick");
endmodule // pin_function_sva

// ==== verif/host_pins.sv ====
// host pin model: reset, sleep, serial select and data, 400 ns rtc clock
// assumes bench requests change just after mclk_i rising edges
module host_pins (
    // requests
    input wire mclk_i,
    input wire [4:0] req_i,
    // pins
    output logic hard_reset_n_o = 1'b1,
    output logic powerdown_o = 1'b0,
    output logic select_n_o = 1'b1,
    output logic data_o = 1'b0,
    output logic ls_clk_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] ph = 3'h0;
    always @(posedge mclk_i)
    begin
        hard_reset_n_o <= !req_i[4];
        powerdown_o <= req_i[3];
        select_n_o <= !req_i[2];
        // an unselected line toggles so stale data never reads as valid
        data_o <= req_i[2] ? req_i[1] : !data_o;
        ph <= req_i[0] ? ph + 3'h1 : 3'h0;
        ls_clk_o <= req_i[0] & ph[2];
    end
endmodule // host_pins

// ==== verif/pin_function_reset_defaults_test.sv ====
// bench: register table, pin defaults, serial, sleep and hard reset
// assumes host_pins and pin_function_sva compiled first
`include "pin_function_defines.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module pin_function_reset_defaults_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [8:0] adr_i = 9'h000;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [3:0] core = 4'h0;
    logic [3:0] gpi = 4'h0;
    logic [3:0] sel_i = 4'h0;
    logic dmbc = 1'b0;
    logic [4:0] req = 5'h00;
    logic [1:0] prv;
    logic [31:0] q;
    wire hrn, pdn, scn, sdi, lsc, ack_o, sdo, sdo_oe, ls_oe, crst, deep, tick, swd, dmd;
    wire [31:0] dat_o;
    wire [3:0] gp_o, gp_oe, gp_lvl;
    wire ls_o;
    int error_cnt = 0;
    int checks = 0;
    int ticks, rises, flips;
    // index, write value, expected read
    logic [22:0] rows [9] = '{{7'h03, 8'h40, 8'h40}, {7'h4e, 8'h04, 8'h04},
        {7'h50, 8'h06, 8'h06}, {7'h51, 8'h15, 8'h15}, {7'h52, 8'h09, 8'h09},
        {7'h61, 8'h00, 8'h00}, {7'h10, 8'h5a, 8'h00}, {7'h60, 8'hff, 8'ha0},
        {7'h4f, 8'h00, 8'h00}};
    host_pins host_pins_i (.mclk_i(mclk_i), .req_i(req), .hard_reset_n_o(hrn),
        .powerdown_o(pdn), .select_n_o(scn), .data_o(sdi), .ls_clk_o(lsc));
    // oscillator-module variant, so the held clock on pin one is seen as well
    pin_function_reset_defaults #(.OSC_MODULE_VARIANT(1)) pin_function_reset_defaults_i (
        .mclk_i(mclk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
        .hard_reset_n_i(hrn), .regulator_powerdown_in_i(pdn), .serial_select_n_i(scn),
        .serial_data_in_i(sdi), .serial_data_out_o(sdo), .serial_data_out_oe_o(sdo_oe),
        .low_speed_clock_pin_i(lsc), .low_speed_clock_pin_o(ls_o),
        .low_speed_clock_pin_oe_o(ls_oe), .general_pin_i(gpi),
        .general_pin_o(gp_o), .general_pin_oe_o(gp_oe), .interrupt_req_i(core[3]),
        .antenna_sel_i(core[2]), .trx_sel_i(core[1]), .spi_read_data_i(core[0]),
        .direct_mode_bit_clock_i(dmbc), .core_reset_o(crst), .deep_sleep_o(deep),
        .rtc_tick_o(tick), .spi_write_data_o(swd), .direct_mode_data_o(dmd),
        .general_pin_level_o(gp_lvl));
    initial forever #25 mclk_i = ~mclk_i;
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // counts pin one clock flips, low speed pin rises and rtc ticks over n cycles
    task automatic watch(input int n);
        flips = 0;
        ticks = 0;
        rises = 0;
        prv = {gp_o[1], lsc};
        for (int i = 0; i < n; i++)
        begin
            @(posedge mclk_i);
            if (i == n - 6)
                req <= 5'h00;
            flips += int'(gp_o[1] !== prv[1]);
            rises += int'(lsc && !prv[0]);
            ticks += int'(tick === 1'b1);
            prv = {gp_o[1], lsc};
        end
    endtask
    task automatic wb(input logic [6:0] idx, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'b00};
        dat_i <= {24'h00_0000, d};
        sel_i <= 4'h1;
        @(posedge mclk_i);
        while (ack_o !== 1'b1 && n < 20)
        begin
            @(posedge mclk_i);
            n++;
        end
        if (ack_o !== 1'b1)
        begin
            error_cnt++;
            print_verdict();
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        sel_i <= 4'h0;
    endtask
    initial
    begin
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        core <= 4'b1010;
        gpi <= 4'ha;
        repeat (6) @(posedge mclk_i);
        `CHK("pin enables", 4'hf, gp_oe)
        `CHK("pin levels", 4'h9, gp_o & 4'hd)
        `CHK("low speed enable", 1'b0, ls_oe)
        `CHK("pin inputs", 4'ha, gp_lvl)
        core <= 4'b0100;
        req <= 5'h01;
        repeat (4) @(posedge mclk_i);
        `CHK("pin levels", 4'h4, gp_o & 4'hd)
        watch(30);
        `CHK("rtc ticks", rises, ticks)
        `CHK("rtc seen", 1'b1, ticks > 0)
        `CHK("clock held", 0, flips)
        foreach (rows[i])
        begin
            wb(rows[i][22:16], 1'b1, rows[i][15:8]);
            wb(rows[i][22:16], 1'b0, 8'h00);
            `CHK("register", {24'h00_0000, rows[i][7:0]}, q)
        end
        wb(7'h4f, 1'b1, 8'h02);
        watch(30);
        `CHK("clock out", 1'b1, flips inside {[14:16]})
        `CHK("low speed drive", 2'b11, {ls_oe, ls_o})
        wb(7'h4f, 1'b1, 8'h00);
        core <= 4'b1011;
        req <= 5'h06;
        repeat (5) @(posedge mclk_i);
        `CHK("pin enables", 4'h9, gp_oe)
        `CHK("pin levels", 4'h1, gp_o & 4'hd)
        `CHK("serial", 3'b111, {swd, sdo_oe, sdo})
        dmbc <= 1'b1;
        core[0] <= 1'b0;
        wb(7'h61, 1'b1, 8'h01);
        repeat (5) @(posedge mclk_i);
        `CHK("direct", 3'b111, {sdo_oe, sdo, dmd})
        wb(7'h61, 1'b1, 8'h00);
        req <= 5'h08;
        repeat (6) @(posedge mclk_i);
        `CHK("sleep", 5'h10, {deep, gp_oe})
        `CHK("released", 1'b0, sdo_oe)
        req <= 5'h00;
        repeat (6) @(posedge mclk_i);
        wb(7'h4f, 1'b0, 8'h00);
        `CHK("after sleep", {24'h00_0000, `RST_PIN_ONE}, {deep, q[30:0]})
        req <= 5'h10;
        repeat (6) @(posedge mclk_i);
        `CHK("core reset", 1'b1, crst)
        wb(7'h4e, 1'b1, 8'h06);
        req <= 5'h00;
        repeat (6) @(posedge mclk_i);
        `CHK("core run", 1'b0, crst)
        wb(7'h4e, 1'b0, 8'h00);
        `CHK("after reset", {24'h00_0000, `RST_PIN_ZERO}, q)
        print_verdict();
    end
endmodule // pin_function_reset_defaults_test
bind pin_function_reset_defaults pin_function_sva pin_function_sva_i (.mclk_i, .rst_i,
    .cyc_i, .stb_i, .ack_o, .dat_o, .hard_reset_n_i, .regulator_powerdown_in_i,
    .serial_select_n_i, .serial_data_in_i, .low_speed_clock_pin_i, .general_pin_oe_o,
    .core_reset_o, .deep_sleep_o, .rtc_tick_o, .spi_write_data_o, .direct_mode_data_o);
